// ### hdl/qprt_pkg.sv
// Purpose: Shared constants and types for the QVGA panel host controller.
// Assumes: System clock of 100 MHz; all counts derive from it.
// Notes: Times keep their printed unit; cycle counts are derived below.
package qprt_pkg;

	// System clock period.
	localparam int SYS_CLK_NS = 10;

	// Pixel clock: 200 ns nominal period, half high and half low.
	localparam int PCLK_NS = 200;
	localparam int PCLK_DIV = PCLK_NS / SYS_CLK_NS;
	localparam int PCLK_HALF = PCLK_DIV / 2;

	// Horizontal layout in pixel clocks, in the order sent.
	localparam int H_SYNC = 8;
	localparam int H_BACK = 4;
	localparam int H_ACTIVE = 240;
	localparam int H_FRONT = 4;
	localparam int H_TOTAL = H_SYNC + H_BACK + H_ACTIVE + H_FRONT;
	localparam int H_ACT_START = H_SYNC + H_BACK;
	localparam int H_ACT_END = H_ACT_START + H_ACTIVE;
	localparam int H_BITS = $clog2(H_TOTAL);

	// Vertical layout in lines, in the order sent.
	localparam int V_SYNC = 2;
	localparam int V_BACK = 1;
	localparam int V_ACTIVE = 320;
	localparam int V_FRONT = 1;
	localparam int V_TOTAL = V_SYNC + V_BACK + V_ACTIVE + V_FRONT;
	localparam int V_ACT_START = V_SYNC + V_BACK;
	localparam int V_ACT_END = V_ACT_START + V_ACTIVE;
	localparam int V_BITS = $clog2(V_TOTAL);

	// Panel reset pulse and delay from its release to chip select.
	localparam int RESET_PULSE_NS = 2000;
	localparam int RESET_PULSE_CYC =
		(RESET_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int SEL_DELAY_NS = 1000000;
	localparam int SEL_DELAY_CYC_DEF =
		(SEL_DELAY_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;

	// Serial clock limits for reads and writes.
	localparam int SER_RD_PERIOD_NS = 450;
	localparam int SER_WR_PERIOD_NS = 100;
	localparam int SER_RD_PULSE_NS = 210;
	localparam int SER_WR_PULSE_NS = 40;
	localparam int SER_RD_A = (SER_RD_PERIOD_NS + 2 * SYS_CLK_NS - 1)
		/ (2 * SYS_CLK_NS);
	localparam int SER_RD_B = (SER_RD_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int SER_WR_A = (SER_WR_PERIOD_NS + 2 * SYS_CLK_NS - 1)
		/ (2 * SYS_CLK_NS);
	localparam int SER_WR_B = (SER_WR_PULSE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
	localparam int SER_RD_HALF = (SER_RD_A > SER_RD_B) ? SER_RD_A : SER_RD_B;
	localparam int SER_WR_HALF = (SER_WR_A > SER_WR_B) ? SER_WR_A : SER_WR_B;
	localparam int SER_HALF_BITS = 8;

	// Serial word length; the command set itself lies outside this block.
	localparam int CMD_BITS = 16;

	// Pixel FIFO depth.
	localparam int PIX_FIFO_DEPTH = 8;

	// One pixel: six bits per colour, all ones is full intensity.
	typedef struct packed {
		logic [5:0] red_pixel_bits;
		logic [5:0] green_pixel_bits;
		logic [5:0] blue_pixel_bits;
	} qprt_pix_t;

	localparam qprt_pix_t PIX_BLACK = 18'h00000;

	// One serial transfer request.
	typedef struct packed {
		logic read;
		logic [CMD_BITS-1:0] data;
	} qprt_cmd_t;

	typedef enum logic [1:0] {
		INIT_RST = 2'h0,
		INIT_WAIT = 2'h1,
		INIT_DONE = 2'h2
	} qprt_init_t;

	typedef enum logic [2:0] {
		SER_IDLE = 3'h0,
		SER_SETUP = 3'h1,
		SER_LOW = 3'h2,
		SER_HIGH = 3'h3,
		SER_HOLD = 3'h4
	} qprt_ser_t;

endpackage

// ### hdl/qprt_sync.sv
// Purpose: Two-stage synchroniser for levels from outside the clock domain.
// Assumes: Input changes slowly compared with sys_clk.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module qprt_sync #(
	parameter int W = 1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] meta_r;
	logic [W-1:0] stable_r;

	// Two flops in series; reset only to constants.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			meta_r <= '0;
			stable_r <= '0;
		end else begin
			meta_r <= din;
			stable_r <= meta_r;
		end
	end

	assign dout = stable_r;
endmodule // qprt_sync
`default_nettype wire

// ### hdl/qprt_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: Single clock; DEPTH is a power of two.
// Notes: Input ready comes from a flop, so it lags a pop by one cycle.
`timescale 1ns/1ps
`default_nettype none
module qprt_fifo #(
	parameter int W = 18,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] inData,
	input wire logic inValid,
	output logic inReady,
	output logic [W-1:0] outData,
	output logic outValid,
	input wire logic outReady
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic [AW:0] count_nxt;
	logic notFull_r;
	logic push;
	logic pop;

	// Push only when ready; pop only when data is held.
	assign push = inValid && notFull_r;
	assign pop = outReady && (count_r != '0);
	assign count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	assign inReady = notFull_r;
	assign outValid = (count_r != '0);
	assign outData = mem[rdPtr_r];

	// Storage has no reset; only pointers, fill count and full flag do.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	// Pointers, fill count and registered full flag.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			notFull_r <= 1'b1;
		end else begin
			wrPtr_r <= wrPtr_r + AW'(push);
			rdPtr_r <= rdPtr_r + AW'(pop);
			count_r <= count_nxt;
			notFull_r <= (count_nxt != (AW+1)'(DEPTH));
		end
	end
endmodule // qprt_fifo
`default_nettype wire

// ### hdl/qprt_host.sv
// Purpose: Host controller driving a 240x320 RGB panel and its serial port.
// Assumes: sys_clk at 100 MHz; pixel source aligns to frameStart.
// Notes: Pixel clock, syncs and serial clock are divided from sys_clk.
//
// Overview of operation
// - Pixel clock nominal 5.0 MHz, within range.
// - Pixel clock high ratio 0.4 to 0.6.
// - Every line lasts 256 pixel clocks.
// - 240 active pixels per line, one per clock.
// - Horizontal front porch is 4 clocks.
// - Horizontal sync at least 2, nominal 8.
// - Horizontal back porch is 4 clocks.
// - Every frame spans 324 lines.
// - 320 consecutive active lines per frame.
// - Vertical front porch is 1 line.
// - Vertical sync at least 1, nominal 2.
// - Vertical back porch is 1 line.
// - Serial clock period: read 450, write 100 ns.
// - Serial clock phases: read 210, write 40 ns.
// - Panel reset held low at least 2 us.
// - Wait 1 ms after reset before select.
// - Always reset the panel at power-up.
// - Serial transfers only while select is low.
// - Six bits per colour, zero is black.
`timescale 1ns/1ps
`default_nettype none
module qprt_host #(
	parameter int unsigned SEL_DELAY_CYC = qprt_pkg::SEL_DELAY_CYC_DEF
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire qprt_pkg::qprt_pix_t pixIn,
	input wire logic pixValid,
	output logic pixReady,
	input wire qprt_pkg::qprt_cmd_t cmdIn,
	input wire logic cmdValid,
	output logic cmdReady,
	output logic rspValid,
	output logic [qprt_pkg::CMD_BITS-1:0] rspData,
	input wire logic panelResetReq,
	output logic initDone,
	output logic frameStart,
	output logic underrun,
	output logic pclk,
	output logic hsyncN,
	output logic vsyncN,
	output qprt_pkg::qprt_pix_t pixOut,
	output logic panelRstN,
	output logic csN,
	output logic scl,
	output logic si,
	input wire logic soIn
);
	import qprt_pkg::*;

	localparam int DIV_BITS = $clog2(PCLK_DIV);
	localparam int BIT_BITS = $clog2(CMD_BITS);

	// ---- Pixel FIFO ----
	qprt_pix_t fifoData;
	logic fifoValid;
	logic fifoPop;

	// The source stalls on pixReady once eight pixels wait for a slot.
	qprt_fifo #(
		.W($bits(qprt_pix_t)),
		.DEPTH(PIX_FIFO_DEPTH)
	) u_pix_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.inData(pixIn),
		.inValid(pixValid),
		.inReady(pixReady),
		.outData(fifoData),
		.outValid(fifoValid),
		.outReady(fifoPop)
	);

	// ---- Pixel clock divider ----
	logic [DIV_BITS-1:0] divCnt_r;
	logic [DIV_BITS-1:0] divCnt_nxt;
	logic pclk_r;
	logic fallTick;

	// Wrap at the divide ratio; the low half starts at PCLK_HALF.
	assign divCnt_nxt = (divCnt_r == DIV_BITS'(PCLK_DIV - 1)) ?
		'0 : divCnt_r + 1'b1;
	assign fallTick = (divCnt_r == DIV_BITS'(PCLK_HALF - 1));

	// High while the count sits in the first half, for an even duty.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			divCnt_r <= DIV_BITS'(PCLK_DIV - 1); // First high phase is full.
			pclk_r <= 1'b0;
		end else begin
			divCnt_r <= divCnt_nxt;
			pclk_r <= (divCnt_nxt < DIV_BITS'(PCLK_HALF));
		end
	end

	// ---- Raster counters ----
	logic [H_BITS-1:0] hCnt_r;
	logic [V_BITS-1:0] vCnt_r;
	logic [H_BITS-1:0] hNext;
	logic [V_BITS-1:0] vNext;
	logic hWrap;
	logic vWrap;

	// Position of the slot that the next falling edge puts on the pins.
	assign hWrap = (hCnt_r == H_BITS'(H_TOTAL - 1));
	assign vWrap = (vCnt_r == V_BITS'(V_TOTAL - 1));
	assign hNext = hWrap ? '0 : hCnt_r + 1'b1;
	assign vNext = !hWrap ? vCnt_r : (vWrap ? '0 : vCnt_r + 1'b1);

	// Decode the slot; sync first, then back porch, active, front porch.
	logic hSyncOn;
	logic vSyncOn;
	logic hActive;
	logic vActive;
	logic slotActive;

	assign hSyncOn = (hNext < H_BITS'(H_SYNC));
	assign vSyncOn = (vNext < V_BITS'(V_SYNC));
	assign hActive = (hNext >= H_BITS'(H_ACT_START)) &&
		(hNext < H_BITS'(H_ACT_END));
	assign vActive = (vNext >= V_BITS'(V_ACT_START)) &&
		(vNext < V_BITS'(V_ACT_END));
	assign slotActive = hActive && vActive;

	// One pixel leaves the FIFO per active slot, at the falling edge.
	assign fifoPop = fallTick && slotActive && fifoValid;

	// Black outside the picture, and black on an empty FIFO.
	qprt_pix_t pixSel;
	assign pixSel = (slotActive && fifoValid) ? fifoData : PIX_BLACK;

	logic hsyncN_r;
	logic vsyncN_r;
	qprt_pix_t pixOut_r;
	logic frameStart_r;
	logic underrun_r;

	// Pins change with the falling pixel clock, a half period before the
	// panel samples on the rising edge, which gives ample setup and hold.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hCnt_r <= H_BITS'(H_TOTAL - 1);
			vCnt_r <= V_BITS'(V_TOTAL - 1);
			hsyncN_r <= 1'b1;
			vsyncN_r <= 1'b1;
			pixOut_r <= PIX_BLACK;
		end else if (fallTick) begin
			hCnt_r <= hNext;
			vCnt_r <= vNext;
			hsyncN_r <= !hSyncOn;
			vsyncN_r <= !vSyncOn;
			pixOut_r <= pixSel;
		end
	end

	// Frame start pulses as the frame's first sync slot reaches the pins; underrun flags a
	// slot that wanted a pixel while the FIFO was empty.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			frameStart_r <= 1'b0;
			underrun_r <= 1'b0;
		end else begin
			frameStart_r <= fallTick && (hNext == '0) && (vNext == '0);
			underrun_r <= fallTick && slotActive && !fifoValid;
		end
	end

	// ---- Panel reset sequencing ----
	qprt_init_t initState_r;
	qprt_init_t initState_nxt;
	logic [31:0] initCnt_r;
	logic initCntDone;
	logic serIdle;

	assign initCntDone = (initCnt_r == 32'h00000000);

	// A later reset request waits for the serial port to go idle, so that
	// no transfer is cut off mid-word.
	always_comb begin
		initState_nxt = initState_r;
		unique case (initState_r)
			INIT_RST: begin
				if (initCntDone) begin
					initState_nxt = INIT_WAIT;
				end
			end
			INIT_WAIT: begin
				if (initCntDone) begin
					initState_nxt = INIT_DONE;
				end
			end
			INIT_DONE: begin
				if (panelResetReq && serIdle) begin
					initState_nxt = INIT_RST;
				end
			end
			default: begin
				initState_nxt = INIT_RST;
			end
		endcase
	end

	logic panelRstN_r;
	logic initDone_r;

	// System reset always starts with a panel reset pulse.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			initState_r <= INIT_RST;
			initCnt_r <= 32'(RESET_PULSE_CYC - 1);
		end else begin
			initState_r <= initState_nxt;
			if (initState_nxt != initState_r) begin
				initCnt_r <= (initState_nxt == INIT_WAIT) ?
					32'(SEL_DELAY_CYC - 1) :
					32'(RESET_PULSE_CYC - 1);
			end else if (!initCntDone) begin
				initCnt_r <= initCnt_r - 32'h00000001;
			end
		end
	end

	// Reset pin low only in the pulse state; select opens after the wait.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			panelRstN_r <= 1'b0;
			initDone_r <= 1'b0;
		end else begin
			panelRstN_r <= (initState_nxt != INIT_RST);
			initDone_r <= (initState_nxt == INIT_DONE);
		end
	end

	// ---- Serial port ----
	logic soSync;

	// SO comes from the panel's own timing, so it is synchronised first.
	qprt_sync #(
		.W(1)
	) u_so_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.din(soIn),
		.dout(soSync)
	);

	qprt_ser_t serState_r;
	qprt_ser_t serState_nxt;
	logic [SER_HALF_BITS-1:0] halfCnt_r;
	logic [SER_HALF_BITS-1:0] halfLen_r;
	logic [BIT_BITS-1:0] bitCnt_r;
	logic [CMD_BITS-1:0] shOut_r;
	logic [CMD_BITS-1:0] shIn_r;
	logic halfDone;
	logic lastBit;
	logic cmdTake;
	logic cmdReady_r;

	assign halfDone = (halfCnt_r == '0);
	assign lastBit = (bitCnt_r == BIT_BITS'(CMD_BITS - 1));
	assign cmdTake = cmdValid && cmdReady_r;
	assign serIdle = (serState_r == SER_IDLE);

	// Each phase lasts one half period: select setup, low, high, hold.
	always_comb begin
		serState_nxt = serState_r;
		unique case (serState_r)
			SER_IDLE: begin
				if (cmdTake) begin
					serState_nxt = SER_SETUP;
				end
			end
			SER_SETUP: begin
				if (halfDone) begin
					serState_nxt = SER_LOW;
				end
			end
			SER_LOW: begin
				if (halfDone) begin
					serState_nxt = SER_HIGH;
				end
			end
			SER_HIGH: begin
				if (halfDone) begin
					serState_nxt = lastBit ? SER_HOLD : SER_LOW;
				end
			end
			SER_HOLD: begin
				if (halfDone) begin
					serState_nxt = SER_IDLE;
				end
			end
			default: begin
				serState_nxt = SER_IDLE;
			end
		endcase
	end

	logic serStep;
	assign serStep = (serState_nxt != serState_r) ||
		(serState_r == SER_HIGH && halfDone);

	// Reads use the slow half period; writes the fast one.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			serState_r <= SER_IDLE;
			halfLen_r <= '0;
			halfCnt_r <= '0;
		end else begin
			serState_r <= serState_nxt;
			if (cmdTake) begin
				halfLen_r <= cmdIn.read ?
					SER_HALF_BITS'(SER_RD_HALF - 1) :
					SER_HALF_BITS'(SER_WR_HALF - 1);
				halfCnt_r <= cmdIn.read ?
					SER_HALF_BITS'(SER_RD_HALF - 1) :
					SER_HALF_BITS'(SER_WR_HALF - 1);
			end else if (serStep) begin
				halfCnt_r <= halfLen_r;
			end else if (!halfDone) begin
				halfCnt_r <= halfCnt_r - 1'b1;
			end
		end
	end

	// Shift out MSB first on the falling edge; capture SO just before
	// the clock falls again, well after the panel's access time.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			shOut_r <= '0;
			shIn_r <= '0;
			bitCnt_r <= '0;
		end else if (cmdTake) begin
			shOut_r <= cmdIn.data;
			bitCnt_r <= '0;
		end else if (serState_r == SER_HIGH && halfDone) begin
			shIn_r <= {shIn_r[CMD_BITS-2:0], soSync};
			shOut_r <= {shOut_r[CMD_BITS-2:0], 1'b0};
			bitCnt_r <= bitCnt_r + 1'b1;
		end
	end

	logic csN_r;
	logic scl_r;
	logic si_r;
	logic rspValid_r;
	logic [CMD_BITS-1:0] rspData_r;

	// Select stays low from setup to hold; the clock idles high.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			csN_r <= 1'b1;
			scl_r <= 1'b1;
			si_r <= 1'b0;
		end else begin
			csN_r <= (serState_nxt == SER_IDLE);
			scl_r <= (serState_nxt != SER_LOW);
			if (serState_nxt == SER_LOW && serState_r != SER_LOW) begin
				si_r <= (serState_r == SER_HIGH) ?
					shOut_r[CMD_BITS-2] : shOut_r[CMD_BITS-1];
			end
		end
	end

	// Commands are only accepted once the panel is out of reset and idle.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmdReady_r <= 1'b0;
			rspValid_r <= 1'b0;
			rspData_r <= '0;
		end else begin
			cmdReady_r <= (initState_nxt == INIT_DONE) &&
				(serState_nxt == SER_IDLE) && !cmdTake && !panelResetReq;
			rspValid_r <= (serState_r == SER_HOLD) && halfDone;
			if (serState_r == SER_HOLD && halfDone) begin
				rspData_r <= shIn_r;
			end
		end
	end

	// Every output leaves from a flop.
	assign pclk = pclk_r;
	assign hsyncN = hsyncN_r;
	assign vsyncN = vsyncN_r;
	assign pixOut = pixOut_r;
	assign frameStart = frameStart_r;
	assign underrun = underrun_r;
	assign panelRstN = panelRstN_r;
	assign initDone = initDone_r;
	assign csN = csN_r;
	assign scl = scl_r;
	assign si = si_r;
	assign cmdReady = cmdReady_r;
	assign rspValid = rspValid_r;
	assign rspData = rspData_r;
endmodule // qprt_host
`default_nettype wire

// ### tb/qprt_host_assertions.sv
// Purpose: Port timing checks for the panel host controller.
// Assumes: sys_clk at 100 MHz; counts come from the shared package.
// Notes: Helper counters measure pins in system clock cycles.
`timescale 1ns/1ps
`default_nettype none
module qprt_host_assertions #(
	parameter int unsigned SEL_DELAY_CYC = 50
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire qprt_pkg::qprt_cmd_t cmdIn,
	input wire logic cmdValid,
	input wire logic cmdReady,
	input wire logic rspValid,
	input wire logic pclk,
	input wire logic hsyncN,
	input wire logic vsyncN,
	input wire qprt_pkg::qprt_pix_t pixOut,
	input wire logic panelRstN,
	input wire logic csN,
	input wire logic scl
);
	import qprt_pkg::*;
	logic [12:0] hCnt_r;
	logic [12:0] hLow_r;
	logic [9:0] vLine_r;
	logic [7:0] sclLow_r;
	logic [15:0] rstLow_r;
	logic [31:0] sel_r;
	logic hSeen_r;
	logic rd_r;
	// hCnt and vLine restart on edges; hLow, sclLow and rstLow clear while their pin idles, sel_r while panel reset is low.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hCnt_r <= '0;
			vLine_r <= '0;
			rstLow_r <= '0;
			sel_r <= '0;
			hSeen_r <= 1'b0;
		end else begin
			hCnt_r <= $fell(hsyncN) ? 13'h1 : hCnt_r + 13'h1;
			hLow_r <= hsyncN ? 13'h0 : hLow_r + 13'h1;
			if ($fell(vsyncN))
				vLine_r <= '0;
			else if ($fell(hsyncN))
				vLine_r <= vLine_r + 10'h1;
			if ($fell(hsyncN))
				hSeen_r <= 1'b1;
			sclLow_r <= scl ? 8'h0 : sclLow_r + 8'h1;
			rstLow_r <= panelRstN ? 16'h0 : rstLow_r + 16'h1;
			sel_r <= panelRstN ? sel_r + 32'h1 : 32'h0;
			if (cmdValid && cmdReady)
				rd_r <= cmdIn.read;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A phase of ten cycles followed by the opposite level.
	sequence s_ten(x);
		x[*8] ##1 x[*2] ##1 !x;
	endsequence
	a_pclk_high: assert property ($rose(pclk) |-> s_ten(pclk))
		else $error("pixel clock high phase wrong");
	a_pclk_low: assert property ($fell(pclk) |-> s_ten(!pclk))
		else $error("pixel clock low phase wrong");
	a_pins_at_fall: assert property (($changed(hsyncN) ||
		$changed(vsyncN) || $changed(pixOut)) |-> $fell(pclk))
		else $error("raster pins moved off the clock fall");
	a_hsync_width: assert property ($rose(hsyncN) |->
		hLow_r == H_SYNC * PCLK_DIV) else $error("hsync width wrong");
	a_line_period: assert property ($fell(hsyncN) && hSeen_r |->
		hCnt_r == H_TOTAL * PCLK_DIV) else $error("line length wrong");
	a_blank_black: assert property (pixOut != PIX_BLACK |->
		hCnt_r >= H_ACT_START * PCLK_DIV && hCnt_r < H_ACT_END * PCLK_DIV
		&& vLine_r >= V_ACT_START && vLine_r < V_ACT_END)
		else $error("pixel data outside the active area");
	a_vsync_width: assert property ($rose(vsyncN) |->
		$fell(hsyncN) && vLine_r == V_SYNC - 1) else $error("vsync width");
	a_frame_len: assert property ($fell(vsyncN) |-> $fell(hsyncN) &&
		(!hSeen_r || vLine_r == V_TOTAL - 1)) else $error("frame length");
	a_rst_width: assert property ($rose(panelRstN) |->
		rstLow_r >= RESET_PULSE_CYC) else $error("panel reset too short");
	a_power_rst: assert property ($fell(rst) |-> !panelRstN)
		else $error("panel reset not driven after power-up");
	a_sel_delay: assert property ($fell(csN) |->
		panelRstN && sel_r >= SEL_DELAY_CYC) else $error("select too early");
	a_scl_low: assert property ($rose(scl) |->
		sclLow_r == (rd_r ? SER_RD_HALF : SER_WR_HALF))
		else $error("serial clock low phase wrong");
	a_scl_in_sel: assert property ($fell(scl) |-> !csN)
		else $error("serial clock outside select");
	a_rsp_at_end: assert property (rspValid |-> $rose(csN))
		else $error("response not at end of select");
endmodule // qprt_host_assertions
bind qprt_host qprt_host_assertions #(.SEL_DELAY_CYC(SEL_DELAY_CYC))
	qprt_host_assertions_inst (.sys_clk(sys_clk), .rst(rst), .cmdIn(cmdIn),
	.cmdValid(cmdValid), .cmdReady(cmdReady), .rspValid(rspValid),
	.pclk(pclk), .hsyncN(hsyncN), .vsyncN(vsyncN), .pixOut(pixOut),
	.panelRstN(panelRstN), .csN(csN), .scl(scl));
`default_nettype wire

// ### tb/qprt_panel_model.sv
// Purpose: Behavioural panel taking the raster and serial words.
// Assumes: Pixels sampled on pclk rising, serial bits on scl rising.
// Notes: Every active slot is logged, so black fills show up too.
`timescale 1ns/1ps
`default_nettype none
module qprt_panel_model #(
	parameter logic [15:0] REPLY = 16'h5ac3
) (
	input wire logic pclk,
	input wire logic hsyncN,
	input wire logic vsyncN,
	input wire qprt_pkg::qprt_pix_t pixOut,
	input wire logic csN,
	input wire logic scl,
	input wire logic si,
	output logic soIn
);
	import qprt_pkg::*;
	qprt_pix_t rxPix[$];
	logic [15:0] rxWord;
	int rxCnt;
	int px;
	int ln = 1000;
	int txIdx;
	logic hPrev = 1'b1;
	logic vPrev = 1'b1;
	initial soIn = 1'b0;
	// A line opens at the first clock with hsync low; a frame likewise.
	always @(posedge pclk) begin
		if (!hsyncN && hPrev) begin
			px = 0;
			ln = (!vsyncN && vPrev) ? 0 : ln + 1;
		end else begin
			px = px + 1;
		end
		hPrev = hsyncN;
		vPrev = vsyncN;
		if (px >= H_ACT_START && px < H_ACT_END && ln >= V_ACT_START &&
			ln < V_ACT_END) begin
			rxPix.push_back(pixOut);
		end
	end
	// Serial words count only while the select is low.
	always @(negedge csN) begin
		rxCnt = 0;
		txIdx = CMD_BITS - 1;
	end
	always @(posedge scl) begin
		if (!csN) begin
			rxWord = {rxWord[14:0], si};
			rxCnt++;
		end
	end
	// Reply bits change on the falling clock, most significant first.
	always @(negedge scl) begin
		if (!csN && txIdx >= 0) begin
			soIn = REPLY[txIdx];
			txIdx--;
		end
	end
	// Released line shows the inverse, so a stale bit cannot match.
	always @(posedge csN) soIn = ~soIn;
endmodule // qprt_panel_model
`default_nettype wire

// ### tb/qprt_host_tb.sv
// Purpose: Self-checking bench for the panel host controller.
// Assumes: 100 MHz sys_clk; short select delay for simulation.
// Notes: Runs into line four of frame one, then serial and re-reset.
`timescale 1ns/1ps
`default_nettype none
module qprt_host_tb;
	import qprt_pkg::*;
	localparam int unsigned SEL_CYC = 50;
	localparam logic [15:0] REPLY = 16'h5ac3;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	qprt_pix_t pixIn = PIX_BLACK;
	qprt_pix_t pixOut;
	qprt_cmd_t cmdIn = '0;
	logic pixValid = 1'b0;
	logic cmdValid = 1'b0;
	logic panelResetReq = 1'b0;
	logic pixReady, cmdReady, rspValid, initDone, frameStart, underrun;
	logic pclk, hsyncN, vsyncN, panelRstN, csN, scl, si, soIn;
	logic [15:0] rspData;
	int error_cnt = 0;
	int total_checks = 0;
	qprt_host #(.SEL_DELAY_CYC(SEL_CYC)) qprt_host_inst (
		.sys_clk(sys_clk), .rst(rst), .pixIn(pixIn), .pixValid(pixValid),
		.pixReady(pixReady), .cmdIn(cmdIn), .cmdValid(cmdValid),
		.cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
		.panelResetReq(panelResetReq), .initDone(initDone),
		.frameStart(frameStart), .underrun(underrun), .pclk(pclk),
		.hsyncN(hsyncN), .vsyncN(vsyncN), .pixOut(pixOut),
		.panelRstN(panelRstN), .csN(csN), .scl(scl), .si(si), .soIn(soIn));
	qprt_panel_model #(.REPLY(REPLY)) qprt_panel_model_inst (
		.pclk(pclk), .hsyncN(hsyncN), .vsyncN(vsyncN), .pixOut(pixOut),
		.csN(csN), .scl(scl), .si(si), .soIn(soIn));
	// Free-running system clock.
	initial forever #5 sys_clk = ~sys_clk;
	task automatic step();
		@(posedge sys_clk);
		#1;
	endtask
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Pattern covers zero and full intensity in red and green; blue spans 0 to 59.
	function automatic qprt_pix_t pat(input logic [7:0] i);
		return {i[5:0], ~i[5:0], i[7:2]};
	endfunction
	// Serial latency window: setup, 16 bits and hold, in half periods.
	function automatic logic inTime(input int lat, input int h);
		return lat >= 34 * h && lat <= 35 * h + 8;
	endfunction
	task automatic ser(input logic rd, input logic [15:0] w, output int lat);
		cmdIn = '{read: rd, data: w};
		cmdValid = 1'b1;
		for (lat = 0; lat < 5000 && cmdReady !== 1'b1; lat++) step();
		step();
		cmdValid = 1'b0;
		for (lat = 0; lat < 3000 && rspValid !== 1'b1; lat++) step();
	endtask
	task automatic test_reset();
		int n;
		check(panelRstN === 1'b0 && csN === 1'b1, "reset levels");
		check(cmdReady === 1'b0, "command taken before init");
		for (n = 0; n < 30 && frameStart !== 1'b1; n++) step();
		check(frameStart === 1'b1 && hsyncN === 1'b0 &&
			vsyncN === 1'b0, "frame start not at both syncs");
		for (n = 0; n < 2000 && initDone !== 1'b1; n++) step();
		check(initDone === 1'b1 && panelRstN === 1'b1, "no init");
		check(n >= RESET_PULSE_CYC, "init too early");
		$display("test_reset done");
	endtask
	task automatic test_pixels();
		int n;
		pixValid = 1'b1;
		for (int i = 0; i < H_ACTIVE; i++) begin
			pixIn = pat(8'(i));
			for (n = 0; n < 20000 && pixReady !== 1'b1; n++) step();
			step();
			if (i == PIX_FIFO_DEPTH - 1) begin
				pixValid = 1'b0;
				step();
				check(pixReady === 1'b0, "fifo did not refuse");
				pixValid = 1'b1;
			end
		end
		pixValid = 1'b0;
		for (n = 0; n < 6000 && underrun !== 1'b1; n++) step();
		check(underrun === 1'b1, "no underrun");
		for (n = 0; n < 200 &&
			qprt_panel_model_inst.rxPix.size() <= H_ACTIVE; n++) step();
		check(qprt_panel_model_inst.rxPix.size() > H_ACTIVE, "short");
		for (int i = 0; i < H_ACTIVE; i++) begin
			check(qprt_panel_model_inst.rxPix[i] === pat(8'(i)),
				"pixel mismatch");
		end
		check(qprt_panel_model_inst.rxPix[H_ACTIVE] === PIX_BLACK,
			"fill not black");
		$display("test_pixels done");
	endtask
	task automatic test_serial();
		int lat;
		ser(1'b0, 16'ha5f0, lat);
		check(qprt_panel_model_inst.rxWord === 16'ha5f0, "write word");
		check(qprt_panel_model_inst.rxCnt == CMD_BITS, "bit count");
		check(inTime(lat, SER_WR_HALF), "write timing");
		ser(1'b1, 16'h0ff1, lat);
		check(rspData === REPLY, "read reply");
		check(inTime(lat, SER_RD_HALF), "read timing");
		$display("test_serial done");
	endtask
	task automatic test_panel_reset();
		int n;
		panelResetReq = 1'b1;
		for (n = 0; n < 50 && panelRstN !== 1'b0; n++) step();
		panelResetReq = 1'b0;
		check(panelRstN === 1'b0 && initDone === 1'b0, "no re-reset");
		check(cmdReady === 1'b0, "command taken in reset");
		for (n = 0; n < 2000 && initDone !== 1'b1; n++) step();
		check(initDone === 1'b1 && n >= RESET_PULSE_CYC, "re-init");
		ser(1'b0, 16'h3c0f, n);
		check(qprt_panel_model_inst.rxWord === 16'h3c0f, "word after");
		$display("test_panel_reset done");
	endtask
	// Watchdog sized well past the first four lines plus serial work.
	initial begin
		#600000;
		error_cnt++;
		test_done();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		test_reset();
		test_pixels();
		test_serial();
		test_panel_reset();
		test_done();
	end
endmodule // qprt_host_tb
`default_nettype wire
